// ### include/flash_host_pkg.sv
// Purpose: Shared constants and types of the serial flash host controller
// Assumes: 20 MHz hclk, serial clock made here by division, mode 0 framing
// Notes:   Register offsets are byte addresses on the AHB-Lite bus
package flash_host_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned SCLK_PERIOD_NS = 400;
	// A least time, so round the half period up
	localparam int unsigned SCLK_HALF_CYC  =
		(SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  HALF_LOAD      = 3'(SCLK_HALF_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Register map and fields
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_ADDR        = 8'h04;
	localparam logic [7:0] REG_WDATA       = 8'h08;
	localparam logic [7:0] REG_RDATA       = 8'h0c;
	localparam logic [7:0] REG_STATUS      = 8'h10;
	localparam int unsigned CTRL_OPC_LSB   = 0;
	localparam int unsigned CTRL_FMT_LSB   = 8;
	localparam int unsigned CTRL_START_BIT = 12;
	localparam int unsigned CTRL_ABORT_BIT = 13;
	localparam int unsigned CTRL_LEN_LSB   = 16;
	localparam int unsigned STAT_WFULL_BIT = 0;
	localparam int unsigned STAT_RVAL_BIT  = 1;
	localparam int unsigned STAT_BUSY_BIT  = 2;
	localparam int unsigned STAT_ABORT_BIT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Clocks per phase
	localparam logic [4:0] CMD_CLK         = 5'h08;
	localparam logic [4:0] ADDR_CLK_SINGLE = 5'h18;
	localparam logic [4:0] ADDR_CLK_DUAL   = 5'h0c;
	localparam logic [4:0] DUMMY_CLK_FAST  = 5'h08;
	localparam logic [4:0] DUMMY_CLK_DIO   = 5'h04;
	localparam logic [4:0] BYTE_CLK_SINGLE = 5'h08;
	localparam logic [4:0] BYTE_CLK_DUAL   = 5'h04;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		FMT_CMD      = 3'h0,
		FMT_ADDR_WR  = 3'h1,
		FMT_READ     = 3'h2,
		FMT_FAST     = 3'h3,
		FMT_DUAL_OUT = 3'h4,
		FMT_DUAL_IO  = 3'h5,
		FMT_CMD_RD   = 3'h6
	} fmt_type;

	typedef enum logic [2:0] {
		PH_CMD   = 3'h0,
		PH_ADDR  = 3'h1,
		PH_DUMMY = 3'h2,
		PH_WR    = 3'h3,
		PH_RD    = 3'h4
	} phase_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOW   = 3'b001,
		ST_HIGH  = 3'b011,
		ST_WAIT  = 3'b010,
		ST_DESEL = 3'b110
	} fsm_type;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} ahb_req_type;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_type;

	typedef struct packed {
		logic do_in;
		logic dio_in;
	} pins_in_type;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic do_out;
		logic do_oe_n;
		logic dio_out;
		logic dio_oe_n;
	} pins_out_type;

	// Values after reset
	localparam pins_out_type PINS_RST = '{cs_n: 1'b1, sclk: 1'b0, do_out: 1'b0,
		do_oe_n: 1'b1, dio_out: 1'b0, dio_oe_n: 1'b1};
	localparam ahb_rsp_type  RSP_RST  = '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};

endpackage

// ### verification/flash_dev_model.sv
// Purpose: Behavioural serial flash at the far end
// Assumes: Mode 0, pull-ups on both data lines
// Notes:   Bench opcodes and sizes; addresses alias above MEM
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int         MEM  = 1024,
	parameter int         SEC  = 64,
	parameter int         BLK  = 256,
	parameter int         PROT = 768,
	parameter int         BUSY = 30000,
	parameter logic [7:0] OP_RD = 8'h03, OP_FAST = 8'h0b, OP_DOUT = 8'h3b, OP_DUALIO = 8'hbb,
	parameter logic [7:0] OP_PROG = 8'h02, OP_SCLR = 8'h20, OP_BCLR = 8'hd8,
	parameter logic [7:0] OP_UNLK = 8'h06, OP_STAT = 8'h05
) (
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic out_w,
	input  wire logic bidir_w,
	output logic      out_q,
	output logic      out_en,
	output logic      bidir_q,
	output logic      bidir_en
);
	logic [7:0]   mem [MEM];
	logic [7:0]   pend [256];
	logic [255:0] pv;
	logic [7:0]   op, sh, b;
	logic [23:0]  a;
	int           n, k, j, sz;
	logic         write_unlock_latch, cycle_busy_flag;
	wire          dual = op == OP_DOUT || op == OP_DUALIO;
	wire          rdop = dual || op == OP_RD || op == OP_FAST || op == OP_STAT;

	// Known contents, no command pending
	initial begin
		for (int i = 0; i < MEM; i++)
			mem[i] = 8'(i * 37 + 5);
		{write_unlock_latch, cycle_busy_flag, out_q, out_en, bidir_q, bidir_en} = '0;
	end
	// Clocks before the data phase
	function automatic int hdr(input logic [7:0] o);
		if (o == OP_FAST || o == OP_DOUT)
			return 40;
		if (o == OP_DUALIO)
			return 24;
		return o == OP_RD || o == OP_PROG || o == OP_SCLR || o == OP_BCLR ? 32 : 8;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Select starts a fresh command
	always @(negedge cs_n) begin
		n = 0;
		op = '0;
		a = '0;
		pv = '0;
	end
	// Inputs taken on rising edges; dummy bits fall through
	always @(posedge sclk) if (!cs_n) begin
		if (n < 8)
			op = {op[6:0], bidir_w};
		else if (op == OP_DUALIO && n < 20)
			a = {a[21:0], out_w, bidir_w};
		else if (hdr(op) > 8 && n < 32 && op != OP_DUALIO)
			a = {a[22:0], bidir_w};
		else if (op == OP_PROG) begin
			sh = {sh[6:0], bidir_w};
			if (n % 8 == 7) begin
				pend[a[7:0]] = sh;
				pv[a[7:0]] = 1'b1;
				a[7:0] = a[7:0] + 8'h01;
			end
		end
		n++;
	end
	// Data out on falling edges; only status reads answered while a cycle runs
	always @(negedge sclk)
		if (!cs_n && rdop && n >= hdr(op) && (!cycle_busy_flag || op == OP_STAT)) begin
			k = n - hdr(op);
			b = op == OP_STAT ? {6'h00, write_unlock_latch, cycle_busy_flag}
				: mem[(a + (dual ? k / 4 : k / 8)) % MEM];
			j = dual ? 6 - 2 * (k % 4) : 7 - k % 8;
			out_q <= dual ? b[j + 1] : b[j];
			bidir_q <= b[j];
			bidir_en <= dual;
			out_en <= 1'b1;
		end
	// Deselect releases lines and may start a timed cycle
	always @(posedge cs_n) begin
		out_en <= 1'b0;
		bidir_en <= 1'b0;
		sz = op == OP_SCLR ? SEC : op == OP_BCLR ? BLK : 256;
		if (op == OP_UNLK && n == 8 && !cycle_busy_flag)
			write_unlock_latch = 1'b1;
		else if (write_unlock_latch && !cycle_busy_flag && n % 8 == 0 && a % MEM < PROT
			&& (op == OP_PROG ? n > 32 : (op == OP_SCLR || op == OP_BCLR) && n == 32)) begin
			for (int i = 0; i < MEM; i++)
				if (i / sz == a % MEM / sz && (op != OP_PROG || pv[i % 256]))
					mem[i] = op == OP_PROG ? mem[i] & pend[i % 256] : 8'hff;
			write_unlock_latch = 1'b0;
			cycle_busy_flag = 1'b1;
			cycle_busy_flag <= #BUSY 1'b0;
		end
	end
endmodule

// ### verification/serial_flash_read_program_erase_tb.sv
// Purpose: Self-checking bench of the serial flash host
// Assumes: Zero-wait slave, pulled-up data lines
// Notes:   Small memory, short busy time
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_flash_read_program_erase_tb;
	localparam int MEM = 1024;
	logic                         hclk, hresetn, clash;
	int                           err_total, checks;
	flash_host_pkg::ahb_req_type  req;
	flash_host_pkg::ahb_rsp_type  rsp;
	flash_host_pkg::pins_in_type  pin;
	flash_host_pkg::pins_out_type pout;
	logic                         out_q, out_en, bidir_q, bidir_en;
	logic [31:0]                  r;
	logic [7:0]                   sh [MEM];
	// Released lines float high through pull-ups
	wire out_w = !pout.do_oe_n ? pout.do_out : out_en ? out_q : 1'b1;
	wire bidir_w = !pout.dio_oe_n ? pout.dio_out : bidir_en ? bidir_q : 1'b1;

	flash_host_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
		.pins_in(pin), .pins_out(pout));
	flash_dev_model #(.MEM(MEM)) fl (.cs_n(pout.cs_n), .sclk(pout.sclk), .out_w(out_w),
		.bidir_w(bidir_w), .out_q(out_q), .out_en(out_en), .bidir_q(bidir_q),
		.bidir_en(bidir_en));
	// Wire levels back to the host; one slave gives hready
	always @* begin
		pin.do_in = out_w;
		pin.dio_in = bidir_w;
		req.hready = rsp.hreadyout;
	end
	// Both ends driving one line is a clash
	always @(posedge hclk)
		if (!pout.dio_oe_n && bidir_en || !pout.do_oe_n && out_en)
			clash <= 1'b1;
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Single transfer; held until hready seen high
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		req.hsel <= 1'b1;
		req.haddr <= {24'h000000, ad};
		req.htrans <= 2'b10;
		req.hwrite <= w;
		req.hsize <= 3'b010;
		do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
		req.htrans <= 2'b00;
		req.hwdata <= wd;
		do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
		r = rsp.hrdata;
	endtask
	task automatic cmd(input logic [7:0] o, input logic [2:0] f, input logic [23:0] ad,
		input logic [15:0] len);
		bus(1'b1, flash_host_pkg::REG_ADDR, {8'h00, ad});
		bus(1'b1, flash_host_pkg::REG_CTRL, {len, 4'h1, 1'b0, f, o});
	endtask
	// Bounded wait on one status bit
	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 3000; i++) begin
			bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
			if (r[b] === v)
				return;
		end
		`CHK("status wait", v, r[b])
	endtask
	task automatic getb(input logic [7:0] e);
		poll(flash_host_pkg::STAT_RVAL_BIT, 1'b1);
		bus(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		`CHK("read byte", e, r[7:0])
	endtask
	task automatic putb(input logic [7:0] d);
		poll(flash_host_pkg::STAT_WFULL_BIT, 1'b0);
		bus(1'b1, flash_host_pkg::REG_WDATA, {24'h0, d});
	endtask
	task automatic done;
		poll(flash_host_pkg::STAT_BUSY_BIT, 1'b0);
	endtask
	task automatic rd(input logic [7:0] o, input logic [2:0] f, input logic [23:0] ad, input int n);
		cmd(o, f, ad, 16'(n));
		for (int i = 0; i < n; i++)
			getb(sh[(ad + i) % MEM]);
		done;
	endtask
	task automatic stat(input logic [7:0] e);
		cmd(fl.OP_STAT, 3'h6, 24'h0, 16'h1);
		getb(e);
		done;
	endtask
	// Poll the flash until its timed cycle ends
	task automatic settle;
		logic [7:0] s;
		for (int i = 0; i < 100; i++) begin
			cmd(fl.OP_STAT, 3'h6, 24'h0, 16'h1);
			poll(flash_host_pkg::STAT_RVAL_BIT, 1'b1);
			bus(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
			s = r[7:0];
			done;
			if (s[0] === 1'b0)
				return;
		end
		`CHK("flash idle", 1'b0, s[0])
	endtask
	// Unlock, program, follow shadow, expect busy or refusal
	task automatic prog(input logic [23:0] ad, input int len, input logic ok);
		logic [7:0]   d;
		logic [7:0]   pg [256];
		logic [255:0] pv;
		pv = '0;
		cmd(fl.OP_UNLK, 3'h0, 24'h0, 16'h0);
		done;
		cmd(fl.OP_PROG, 3'h1, ad, 16'(len));
		for (int i = 0; i < len; i++) begin
			d = 8'(i * 29 + i / 2 + 7);
			pg[8'(ad[7:0] + i)] = d;
			pv[8'(ad[7:0] + i)] = ok;
			putb(d);
		end
		done;
		for (int i = 0; i < 256; i++)
			if (pv[i])
				sh[{ad[23:8], 8'(i)} % MEM] &= pg[i];
		stat(ok ? 8'h01 : 8'h02);
		settle;
	endtask
	// Erase, read elsewhere while busy, check both edges
	task automatic clr(input logic [7:0] o, input logic [23:0] ad, input int sz);
		int lo;
		lo = ad % MEM / sz * sz;
		cmd(fl.OP_UNLK, 3'h0, 24'h0, 16'h0);
		done;
		cmd(o, 3'h1, ad, 16'h0);
		done;
		cmd(fl.OP_RD, 3'h2, 24'h0003f0, 16'h1);
		getb(8'hff);
		done;
		for (int i = 0; i < MEM; i++)
			if (i / sz == lo / sz)
				sh[i] = 8'hff;
		settle;
		rd(fl.OP_RD, 3'h2, 24'(lo - 2), 4);
		rd(fl.OP_RD, 3'h2, 24'(lo + sz - 2), 4);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_read;
		rd(fl.OP_RD, 3'h2, 24'he003fe, 4);
		rd(fl.OP_FAST, 3'h3, 24'h000105, 3);
		rd(fl.OP_DOUT, 3'h4, 24'h0003fe, 3);
		rd(fl.OP_DUALIO, 3'h5, 24'h000105, 3);
		$display("test reads done");
	endtask
	task t_prog;
		cmd(fl.OP_PROG, 3'h1, 24'h000040, 16'h1);
		putb(8'h00);
		done;
		stat(8'h00);
		rd(fl.OP_RD, 3'h2, 24'h00003f, 3);
		prog(24'h0000fe, 258, 1'b1);
		rd(fl.OP_RD, 3'h2, 24'h0000fc, 8);
		rd(fl.OP_RD, 3'h2, 24'h000000, 4);
		prog(24'h000205, 1, 1'b1);
		rd(fl.OP_RD, 3'h2, 24'h000204, 3);
		prog(24'(fl.PROT + 16), 2, 1'b0);
		rd(fl.OP_RD, 3'h2, 24'(fl.PROT + 16), 2);
		$display("test program done");
	endtask
	task t_abort;
		cmd(fl.OP_RD, 3'h2, 24'h000010, 16'h4);
		getb(sh[16]);
		bus(1'b1, flash_host_pkg::REG_CTRL, 32'h00002000);
		done;
		bus(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		`CHK("line released", 1'b0, out_en)
		cmd(fl.OP_UNLK, 3'h0, 24'h0, 16'h0);
		done;
		cmd(fl.OP_PROG, 3'h1, 24'h000280, 16'h2);
		putb(8'h00);
		putb(8'h00);
		repeat (20) @(posedge hclk);
		bus(1'b1, flash_host_pkg::REG_CTRL, 32'h00002000);
		done;
		stat(8'h02);
		rd(fl.OP_RD, 3'h2, 24'h000280, 2);
		$display("test abort done");
	endtask
	task close_out;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		{clash, err_total, checks} = '0;
		{req.hsel, req.htrans} = '0;
		hresetn = 1'b0;
		for (int i = 0; i < MEM; i++)
			sh[i] = 8'(i * 37 + 5);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("idle select", 1'b1, pout.cs_n)
		t_read;
		t_prog;
		clr(fl.OP_SCLR, 24'h0002c5, fl.SEC);
		clr(fl.OP_BCLR, 24'h000150, fl.BLK);
		$display("test erase done");
		t_abort;
		`CHK("line clash", 1'b0, clash)
		close_out;
	end
	// Hang guard above the expected run
	initial begin
		#4000000;
		`CHK("watchdog", 1'b0, 1'b1)
		close_out;
	end
endmodule

// ### verilog/flash_host_ctrl.sv
// Purpose: AHB-Lite host running flash read, program and erase commands
// Assumes: Software unlocks before program or erase and polls busy
// Notes:   Data passes one byte at a time; the clock stalls low while
//          software is behind, so nothing is lost
`timescale 1ns/1ps

// Operation
// R1: Opcode then 24-bit address MSB first, device samples on rising clock.
// R2: Device shifts read data out on falling clock edges from addressed byte.
// R3: Address advances each byte so reads stream without new commands.
// R4: Reads wrap from top address to zero while select stays low.
// R5: Host ends a read by raising select, even mid-byte; output stops.
// R6: Reads during a program or erase cycle are ignored by the device.
// R7: Fast read adds one dummy byte after the address before data.
// R8: Dual-output read returns two bits per clock on both data lines.
// R9: Dual-output read has eight dummy clocks after single-lane address.
// R10: Host releases bidirectional line before first dual-output data bit.
// R11: Dual input-output read moves address and data two bits per clock, four dummies.
// R12: Host releases both data lines before first dual input-output data bit.
// R13: Program and erase need a prior unlock command, else ignored.
// R14: Program is opcode, three address bytes, data bytes, select held low.
// R15: Program data past page end wraps to the page start.
// R16: More than a page of data keeps only the last 256 bytes.
// R17: Short program changes only the addressed bytes of the page.
// R18: Program runs only if select rises right after a byte's eighth bit.
// R19: Qualifying select rise starts a timed cycle, busy set, unlock cleared.
// R20: Program or erase into a protected range is refused.
// R21: Sector erase sets a sector to ones, select rising on a byte boundary.
// R22: Block erase sets a block to ones, same rules as sector erase.
// R23: Status register busy flag can be polled during a timed cycle.
// R24: Sector and block erase carry a 24-bit address after the opcode.
// R25: Two-bit transfers put even bit on bidirectional line, odd on output.
module flash_host_ctrl (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire flash_host_pkg::ahb_req_type  ahb_req,
	output wire flash_host_pkg::ahb_rsp_type  ahb_rsp,
	input  wire flash_host_pkg::pins_in_type  pins_in,
	output wire flash_host_pkg::pins_out_type pins_out
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		flash_host_pkg::fsm_type      fsm;
		flash_host_pkg::phase_type    phase;
		flash_host_pkg::fmt_type      fmt;
		logic [7:0]                   opcode;
		logic [23:0]                  addr;
		logic [15:0]                  len;
		logic [2:0]                   div;
		logic [4:0]                   clk_left;
		logic [31:0]                  shift;
		logic [7:0]                   rx;
		logic [7:0]                   wdata;
		logic                         wvalid;
		logic [7:0]                   rdata;
		logic                         rvalid;
		logic                         aborted;
		flash_host_pkg::pins_out_type pins;
		flash_host_pkg::pins_in_type  sync1;
		flash_host_pkg::pins_in_type  sync2;
		logic                         ap_valid;
		logic                         ap_write;
		logic [7:0]                   ap_addr;
		flash_host_pkg::ahb_rsp_type  rsp;
	} state_type;

	state_type   st_reg;
	state_type   st_next;
	logic        take;
	logic        rd_take;
	logic        dual;
	logic [31:0] sh_next;
	logic [31:0] stat;

	// Outputs from flops
	assign ahb_rsp  = st_reg.rsp;
	assign pins_out = st_reg.pins;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		// Pins come from another domain: two flops before use
		st_next.sync1 = pins_in;
		st_next.sync2 = st_reg.sync1;

		// Two-bit lanes
		dual = (st_reg.phase == flash_host_pkg::PH_ADDR &&
			st_reg.fmt == flash_host_pkg::FMT_DUAL_IO) ||
			(st_reg.phase == flash_host_pkg::PH_RD &&
			(st_reg.fmt == flash_host_pkg::FMT_DUAL_OUT ||
			st_reg.fmt == flash_host_pkg::FMT_DUAL_IO)); // [R8] [R11]
		sh_next = dual ? {st_reg.shift[29:0], 2'b00} : {st_reg.shift[30:0], 1'b0};

		// Address phase; reads answer with no wait
		take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
		rd_take = take && !ahb_req.hwrite && ahb_req.haddr[7:0] == flash_host_pkg::REG_RDATA;
		st_next.ap_valid = take;
		st_next.ap_write = ahb_req.hwrite;
		st_next.ap_addr  = ahb_req.haddr[7:0];
		stat = 32'h0;
		stat[flash_host_pkg::STAT_WFULL_BIT] = st_reg.wvalid;
		stat[flash_host_pkg::STAT_RVAL_BIT]  = st_reg.rvalid;
		stat[flash_host_pkg::STAT_BUSY_BIT]  = st_reg.fsm != flash_host_pkg::ST_IDLE;
		stat[flash_host_pkg::STAT_ABORT_BIT] = st_reg.aborted;
		st_next.rsp.hrdata = 32'h0;
		if (take && !ahb_req.hwrite) begin
			case (ahb_req.haddr[7:0])
				flash_host_pkg::REG_CTRL:   st_next.rsp.hrdata =
					{st_reg.len, 5'h00, st_reg.fmt, st_reg.opcode};
				flash_host_pkg::REG_ADDR:   st_next.rsp.hrdata = {8'h00, st_reg.addr};
				flash_host_pkg::REG_RDATA:  st_next.rsp.hrdata = {24'h000000, st_reg.rdata};
				flash_host_pkg::REG_STATUS: st_next.rsp.hrdata = stat;
				default:                    st_next.rsp.hrdata = 32'h0;
			endcase
		end
		// Reading frees the slot
		if (rd_take) begin
			st_next.rvalid = 1'b0;
		end

		// Serial engine
		case (st_reg.fsm)
			flash_host_pkg::ST_IDLE: begin
				st_next.div = flash_host_pkg::HALF_LOAD;
			end
			flash_host_pkg::ST_LOW: begin
				if (st_reg.aborted) begin
					st_next.fsm = flash_host_pkg::ST_DESEL; // [R5]
					st_next.div = flash_host_pkg::HALF_LOAD;
				end else if (st_reg.div != 3'h0) begin
					st_next.div = st_reg.div - 3'h1;
				end else begin
					// Rising edge: both ends sample
					st_next.pins.sclk = 1'b1; // [R1] [R7]
					st_next.div       = flash_host_pkg::HALF_LOAD;
					st_next.clk_left  = st_reg.clk_left - 5'h01;
					st_next.fsm       = flash_host_pkg::ST_HIGH;
					if (st_reg.phase == flash_host_pkg::PH_RD) begin
						// Odd bit on output, even on bidir
						st_next.rx = dual ?
							{st_reg.rx[5:0], st_reg.sync2.do_in, st_reg.sync2.dio_in} :
							{st_reg.rx[6:0], st_reg.sync2.do_in}; // [R2] [R25]
					end
				end
			end
			flash_host_pkg::ST_HIGH: begin
				if (st_reg.div != 3'h0) begin
					st_next.div = st_reg.div - 3'h1;
				end else begin
					st_next.pins.sclk = 1'b0;
					st_next.div       = flash_host_pkg::HALF_LOAD;
					if (st_reg.aborted) begin
						st_next.fsm = flash_host_pkg::ST_DESEL; // [R5]
					end else if (st_reg.clk_left != 5'h00) begin
						// Next bit or pair, most significant first
						st_next.shift = sh_next;
						st_next.fsm   = flash_host_pkg::ST_LOW;
						if (dual) begin
							st_next.pins.do_out  = sh_next[31];
							st_next.pins.dio_out = sh_next[30]; // [R25]
						end else begin
							st_next.pins.dio_out = sh_next[31]; // [R1]
						end
					end else begin
						case (st_reg.phase)
							flash_host_pkg::PH_CMD: begin
								st_next.shift = {st_reg.addr, 8'h00};
								st_next.fsm   = flash_host_pkg::ST_LOW;
								st_next.phase = flash_host_pkg::PH_ADDR;
								if (st_reg.fmt == flash_host_pkg::FMT_CMD) begin
									// Unlock and other bare opcodes end here
									st_next.fsm = flash_host_pkg::ST_DESEL; // [R13]
								end else if (st_reg.fmt == flash_host_pkg::FMT_CMD_RD) begin
									// Status poll while a timed cycle runs
									st_next.phase = flash_host_pkg::PH_RD; // [R23]
									st_next.pins.dio_oe_n = 1'b1;
									st_next.fsm   = flash_host_pkg::ST_WAIT;
								end else if (st_reg.fmt == flash_host_pkg::FMT_DUAL_IO) begin
									st_next.clk_left     = flash_host_pkg::ADDR_CLK_DUAL; // [R11]
									st_next.pins.do_out  = st_reg.addr[23];
									st_next.pins.dio_out = st_reg.addr[22];
									st_next.pins.do_oe_n = 1'b0;
								end else begin
									st_next.clk_left     = flash_host_pkg::ADDR_CLK_SINGLE; // [R24]
									st_next.pins.dio_out = st_reg.addr[23]; // [R1]
								end
							end
							flash_host_pkg::PH_ADDR: begin
								// Both lines let go before any data comes back
								st_next.pins.do_oe_n  = 1'b1; // [R12]
								st_next.pins.dio_oe_n = 1'b1; // [R10]
								st_next.phase         = flash_host_pkg::PH_RD;
								st_next.fsm           = flash_host_pkg::ST_WAIT;
								case (st_reg.fmt)
									flash_host_pkg::FMT_FAST, flash_host_pkg::FMT_DUAL_OUT: begin
										st_next.phase    = flash_host_pkg::PH_DUMMY; // [R7] [R9]
										st_next.clk_left = flash_host_pkg::DUMMY_CLK_FAST;
										st_next.fsm      = flash_host_pkg::ST_LOW;
									end
									flash_host_pkg::FMT_DUAL_IO: begin
										st_next.phase    = flash_host_pkg::PH_DUMMY;
										st_next.clk_left = flash_host_pkg::DUMMY_CLK_DIO; // [R11]
										st_next.fsm      = flash_host_pkg::ST_LOW;
									end
									flash_host_pkg::FMT_ADDR_WR: begin
										// Program data follows; erase has none
										st_next.phase         = flash_host_pkg::PH_WR; // [R14]
										st_next.pins.dio_oe_n = 1'b0;
									end
									flash_host_pkg::FMT_READ: begin
										st_next.phase = flash_host_pkg::PH_RD;
									end
									default: begin
										st_next.fsm = flash_host_pkg::ST_DESEL;
									end
								endcase
							end
							flash_host_pkg::PH_DUMMY: begin
								st_next.phase = flash_host_pkg::PH_RD;
								st_next.fsm   = flash_host_pkg::ST_WAIT;
							end
							flash_host_pkg::PH_RD: begin
								// Byte complete; device moves its address on by itself
								st_next.rdata  = st_reg.rx; // [R3] [R4]
								st_next.rvalid = 1'b1;
								st_next.len    = st_reg.len - 16'h0001;
								st_next.fsm    = flash_host_pkg::ST_WAIT;
							end
							default: begin
								st_next.len = st_reg.len - 16'h0001;
								st_next.fsm = flash_host_pkg::ST_WAIT;
							end
						endcase
					end
				end
			end
			flash_host_pkg::ST_WAIT: begin
				// Clock parked low, so select rises here on a byte boundary; an abort in low or high ends mid-byte
				st_next.div = flash_host_pkg::HALF_LOAD;
				if (st_reg.aborted || st_reg.len == 16'h0000) begin
					st_next.fsm = flash_host_pkg::ST_DESEL; // [R18] [R21] [R22]
				end else if (st_reg.phase == flash_host_pkg::PH_WR && st_reg.wvalid) begin
					st_next.shift        = {st_reg.wdata, 24'h000000};
					st_next.pins.dio_out = st_reg.wdata[7];
					st_next.wvalid       = 1'b0;
					st_next.clk_left     = flash_host_pkg::BYTE_CLK_SINGLE;
					st_next.fsm          = flash_host_pkg::ST_LOW;
				end else if (st_reg.phase == flash_host_pkg::PH_RD && !st_reg.rvalid) begin
					st_next.clk_left = dual ? flash_host_pkg::BYTE_CLK_DUAL :
						flash_host_pkg::BYTE_CLK_SINGLE; // [R8]
					st_next.fsm      = flash_host_pkg::ST_LOW;
				end
			end
			flash_host_pkg::ST_DESEL: begin
				// Half a period with clock low, then half with select high
				if (st_reg.div != 3'h0) begin
					st_next.div = st_reg.div - 3'h1;
				end else if (!st_reg.pins.cs_n) begin
					st_next.pins.cs_n = 1'b1; // [R5] [R18] [R19]
					st_next.div       = flash_host_pkg::HALF_LOAD;
				end else begin
					st_next.fsm     = flash_host_pkg::ST_IDLE;
					st_next.aborted = 1'b0;
				end
			end
			default: begin
				st_next.fsm  = flash_host_pkg::ST_IDLE;
				st_next.pins = flash_host_pkg::PINS_RST;
			end
		endcase
		// Entering deselect releases both data lines
		if (st_next.fsm == flash_host_pkg::ST_DESEL && st_reg.fsm != flash_host_pkg::ST_DESEL) begin
			st_next.pins.do_oe_n  = 1'b1;
			st_next.pins.dio_oe_n = 1'b1;
		end

		// Bus data phase writes; set of the byte slot wins over the engine's take
		if (st_reg.ap_valid && st_reg.ap_write) begin
			case (st_reg.ap_addr)
				flash_host_pkg::REG_CTRL: begin
					if (st_reg.fsm == flash_host_pkg::ST_IDLE &&
						ahb_req.hwdata[flash_host_pkg::CTRL_START_BIT]) begin
						st_next.opcode = ahb_req.hwdata[flash_host_pkg::CTRL_OPC_LSB +: 8];
						st_next.fmt    = flash_host_pkg::fmt_type'(
							ahb_req.hwdata[flash_host_pkg::CTRL_FMT_LSB +: 3]);
						st_next.len    = ahb_req.hwdata[flash_host_pkg::CTRL_LEN_LSB +: 16];
						st_next.phase  = flash_host_pkg::PH_CMD;
						st_next.clk_left = flash_host_pkg::CMD_CLK;
						st_next.shift  = {ahb_req.hwdata[flash_host_pkg::CTRL_OPC_LSB +: 8],
							24'h000000};
						st_next.pins.cs_n     = 1'b0;
						st_next.pins.dio_out  = ahb_req.hwdata[flash_host_pkg::CTRL_OPC_LSB + 7];
						st_next.pins.dio_oe_n = 1'b0;
						st_next.div    = flash_host_pkg::HALF_LOAD;
						st_next.fsm    = flash_host_pkg::ST_LOW; // [R1]
					end else if (st_reg.fsm != flash_host_pkg::ST_IDLE &&
						ahb_req.hwdata[flash_host_pkg::CTRL_ABORT_BIT]) begin
						st_next.aborted = 1'b1; // [R5]
					end
				end
				flash_host_pkg::REG_ADDR: begin
					if (st_reg.fsm == flash_host_pkg::ST_IDLE) begin
						st_next.addr = ahb_req.hwdata[23:0];
					end
				end
				flash_host_pkg::REG_WDATA: begin
					st_next.wdata  = ahb_req.hwdata[7:0];
					st_next.wvalid = 1'b1;
				end
				default: begin
					st_next.wvalid = st_next.wvalid;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg      <= '0;
			st_reg.fsm  <= flash_host_pkg::ST_IDLE;
			st_reg.pins <= flash_host_pkg::PINS_RST;
			st_reg.rsp  <= flash_host_pkg::RSP_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_high_run;
		pins_out.sclk [*4];
	endsequence
	sequence s_low_run;
		!pins_out.sclk [*4];
	endsequence

	AST_FIRST_EDGE: assert property ($fell(pins_out.cs_n) |-> s_low_run ##1 pins_out.sclk) // [R1]
		else $error("first edge early");
	AST_SCLK_HIGH: assert property ($rose(pins_out.sclk) |-> s_high_run ##1 !pins_out.sclk) // [R2]
		else $error("clock high time");
	AST_SCLK_LOW: assert property ($fell(pins_out.sclk) |-> s_low_run) // [R2]
		else $error("clock low time");
	AST_CS_CLK_LOW: assert property ($rose(pins_out.cs_n) |-> // [R5]
		!pins_out.sclk && $past(!pins_out.sclk))
		else $error("select rose, clock high");
	AST_BYTE_BOUND: assert property ($rose(pins_out.cs_n) && !st_reg.aborted && // [R18]
		st_reg.phase == flash_host_pkg::PH_WR |-> st_reg.clk_left == 5'h00)
		else $error("select rose mid byte");
	AST_DIO_FREE: assert property (st_reg.fsm != flash_host_pkg::ST_IDLE && // [R10]
		st_reg.phase inside {flash_host_pkg::PH_DUMMY, flash_host_pkg::PH_RD}
		|-> pins_out.dio_oe_n)
		else $error("bidir driven");
	AST_DO_FREE: assert property ( // [R12]
		st_reg.phase inside {flash_host_pkg::PH_DUMMY, flash_host_pkg::PH_RD}
		|-> pins_out.do_oe_n)
		else $error("output driven");
	AST_DUMMY_LEN: assert property ($rose(st_reg.phase == flash_host_pkg::PH_DUMMY) |-> // [R9] [R11]
		st_reg.clk_left == (st_reg.fmt == flash_host_pkg::FMT_DUAL_IO ? 5'h04 : 5'h08))
		else $error("dummy count");
	AST_RDATA_KEPT: assert property ((st_reg.rvalid && !rd_take) |=> st_reg.rvalid) // [R3]
		else $error("read byte lost");
	AST_BUS_OKAY: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
		else $error("bus not okay");

endmodule
